/* File: core/irq_ext_vec_defines.vh */
`ifndef IRQ_EXT_VEC_DEFINES_VH
`define IRQ_EXT_VEC_DEFINES_VH
// APB byte offsets
`define OFS_CTL_BASE 8'h00
`define OFS_PRIMASK 8'h1c
`define OFS_INSVC 8'h20
`define OFS_REQ 8'h24
`define OFS_STAT 8'h28
// Control register fields
`define CTL_PRI_MSB 2
`define CTL_MASK 3
`define CTL_LEVEL 4
`define CTL_CASC 5
`define CTL_NEST_SEL 6
`define CTL_RESET 7'h0f
`define PRI_LOWEST 3'h7
// Groups: timers, serial, ext4, ext0..ext3
`define NUM_GRP 7
`define NUM_SRC 10
// Fixed vector types
`define TYPE_TMR0 8'h08
`define TYPE_TMR1 8'h12
`define TYPE_TMR2 8'h13
`define TYPE_SRX 8'h14
`define TYPE_STX 8'h15
`define TYPE_EXT4 8'h11
`define TYPE_EXT0 8'h0c
`define TYPE_EXT1 8'h0d
`define TYPE_EXT2 8'h0e
`define TYPE_EXT3 8'h0f
// Source indices in default order
`define SRC_EXT0 4'h6
`define SRC_EXT1 4'h7
// Timing in clock cycles
`define RESP_INT_CYC 6'h2a
`define IDLE_TS 6'h02
// Bus status codes
`define BUS_STS_ACK 3'h0
`define BUS_STS_IDLE 3'h7
`endif

/* File: core/irq_ext_vec.v */
// Contract
// - Ext0/ext1 direct or cascaded mode from their cascade bits.
// - Edge mode requests only after a low-to-high transition.
// - Level mode: sustained high level is a request.
// - Edge mode rearms after input low at least one cycle.
// - External requests not latched; request drops when input drops.
// - Cascaded acknowledge runs two cycles with the paired strobe.
// - Acceptance sets in-service bit and clears request bit, except for a level-mode pin that is still high.
// - Same line blocked while in service unless special nesting.
// - Internal vectoring gives type times four as vector address.
// - Vector types fixed per source.
// - Equal priorities resolved by fixed default order.
// - Internal vectoring runs no external acknowledge cycles.
// - Internally vectored response takes 42 clocks.
// - Type read from low 8 data bits in second cycle, times four.
// - Bus lock held across both acknowledge cycles.
// - Two idle states between the acknowledge cycles.
// - Acknowledge cycle extended until ready returns.
// - Both strobes never active together.
// - Acknowledge status on bus status lines while a strobe is active.
// - Overall response 42 to 55 clocks, more with wait states; here a cascaded vector comes 5 clocks after acceptance.
// - All priority levels reset to lowest, 111.
`timescale 1ns/1ps
`include "irq_ext_vec_defines.vh"
module irq_ext_vec (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire [2:0] i_tmr_evt,
    input wire i_ser_rx_evt,
    input wire i_ser_tx_evt,
    input wire i_ext_irq_zero,
    input wire i_ext_irq_one,
    input wire i_ext_irq_two,
    input wire i_ext_irq_three,
    input wire i_ext_irq_four,
    output reg o_irq_req,
    input wire i_irq_ack,
    input wire i_ready,
    input wire [7:0] i_ad_low,
    output reg [9:0] o_vec_addr,
    output reg o_vec_valid,
    output reg o_ack_strobe_zero_n,
    output reg o_ack_strobe_one_n,
    output reg o_bus_lock,
    output reg [2:0] o_bus_status_lines
);

localparam ST_IDLE = 3'h0;
localparam ST_INT_WAIT = 3'h1;
localparam ST_ACK1 = 3'h2;
localparam ST_GAP = 3'h3;
localparam ST_ACK2 = 3'h4;
localparam ST_DONE = 3'h5;

////////////////////////////////////////////////////////////////////////
// Source helpers

function [2:0] grp_of;
    input [3:0] s;
    reg [3:0] t;
    begin
        t = s - 4'h3;
        if (s < 4'h3) begin
            grp_of = 3'h0;
        end else if (s < 4'h5) begin
            grp_of = 3'h1;
        end else begin
            grp_of = t[2:0];
        end
    end
endfunction

function [7:0] type_of;
    input [3:0] s;
    begin
        case (s)
            4'h0: type_of = `TYPE_TMR0;
            4'h1: type_of = `TYPE_TMR1;
            4'h2: type_of = `TYPE_TMR2;
            4'h3: type_of = `TYPE_SRX;
            4'h4: type_of = `TYPE_STX;
            4'h5: type_of = `TYPE_EXT4;
            4'h6: type_of = `TYPE_EXT0;
            4'h7: type_of = `TYPE_EXT1;
            4'h8: type_of = `TYPE_EXT2;
            default: type_of = `TYPE_EXT3;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Registers and state

reg [6:0] ctl_r [0:6];
reg [2:0] primask_r;
reg [6:0] insvc_r;
reg [4:0] int_req_r;
wire [4:0] ext_req;
reg [31:0] prdata_nxt;
reg [3:0] win_r;
reg [3:0] cur_r;
reg [2:0] state_r;
reg [5:0] cnt_r;
reg [9:0] elig;
reg best_found;
reg [3:0] best_idx;
reg [2:0] best_pri;
reg [6:0] cg;
reg [2:0] g;
integer i;
integer j;

wire [4:0] ext_in = {i_ext_irq_three, i_ext_irq_two, i_ext_irq_one, i_ext_irq_zero, i_ext_irq_four};
// Ext2/ext3 pins carry the strobes once ext0/ext1 are cascaded
wire [4:0] pin_free = {~ctl_r[4][`CTL_CASC], ~ctl_r[3][`CTL_CASC], 3'h7};
wire [9:0] req = {ext_req & pin_free, int_req_r};
// A late acknowledge for a winner that has since dropped is ignored
wire acc = (state_r == ST_IDLE) & o_irq_req & i_irq_ack & elig[win_r];
wire [9:0] clr = acc ? (10'h001 << win_r) : 10'h000;
wire [2:0] win_g = grp_of(win_r);
wire casc = ((win_r == `SRC_EXT0) & ctl_r[3][`CTL_CASC]) |
    ((win_r == `SRC_EXT1) & ctl_r[4][`CTL_CASC]);
wire [7:0] t_int = type_of(cur_r);

wire acc_phase = i_psel & i_penable & o_pready;
wire wr = acc_phase & i_pwrite;
wire ctl_hit = (i_paddr[1:0] == 2'h0) & (i_paddr < `OFS_PRIMASK);
wire [2:0] ctl_idx = i_paddr[4:2];
wire mapped = (i_paddr[1:0] == 2'h0) & (i_paddr <= `OFS_STAT);
// Internal events are latched; an event wins over a same-cycle clear
wire [4:0] int_req_nxt = (int_req_r & ~clr[4:0]) | {i_ser_tx_evt, i_ser_rx_evt, i_tmr_evt};
// Hardware set on acceptance wins over a software write
wire insvc_wr = wr & (i_paddr == `OFS_INSVC);
wire [6:0] insvc_set = acc ? (7'h01 << win_g) : 7'h00;
wire [6:0] insvc_nxt = (insvc_wr ? i_pwdata[6:0] : insvc_r) | insvc_set;

////////////////////////////////////////////////////////////////////////
// Arbitration

always @* begin
    elig = 10'h000;
    best_found = 1'b0;
    best_idx = 4'h0;
    best_pri = `PRI_LOWEST;
    g = 3'h0;
    cg = 7'h00;
    for (i = 0; i < `NUM_SRC; i = i + 1) begin
        g = grp_of(i[3:0]);
        cg = ctl_r[g];
        // Nesting bit only exists for ext0 and ext1
        elig[i] = req[i] & ~cg[`CTL_MASK] &
            ~(insvc_r[g] & ~((g == 3'h3 || g == 3'h4) & cg[`CTL_NEST_SEL])) &
            (cg[`CTL_PRI_MSB:0] <= primask_r);
        // Strict compare keeps the lower index on a tie
        if (elig[i] && (!best_found || cg[`CTL_PRI_MSB:0] < best_pri)) begin
            best_found = 1'b1;
            best_idx = i[3:0];
            best_pri = cg[`CTL_PRI_MSB:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Request capture

always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        int_req_r <= 5'h00;
    end else begin
        int_req_r <= int_req_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// External pin cells

genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_pin
        irq_ext_pin_cell u_pin (
            .i_ref_clk(i_ref_clk),
            .i_arst_n(i_arst_n),
            .i_pin(ext_in[gi]),
            .i_level_mode(ctl_r[gi + 2][`CTL_LEVEL]),
            .i_clr(clr[gi + 5]),
            .o_req(ext_req[gi])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// Read data

// Reserved bits and unmapped offsets read as zero
always @* begin
    prdata_nxt = 32'h00000000;
    if (ctl_hit) begin
        prdata_nxt = {25'h0000000, ctl_r[ctl_idx]};
    end else if (i_paddr == `OFS_PRIMASK) begin
        prdata_nxt = {29'h00000000, primask_r};
    end else if (i_paddr == `OFS_INSVC) begin
        prdata_nxt = {25'h0000000, insvc_r};
    end else if (i_paddr == `OFS_REQ) begin
        prdata_nxt = {22'h000000, req};
    end else if (i_paddr == `OFS_STAT) begin
        prdata_nxt = {25'h0000000, state_r, cur_r};
    end
end

////////////////////////////////////////////////////////////////////////
// APB slave

always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        for (j = 0; j < `NUM_GRP; j = j + 1) begin
            ctl_r[j] <= `CTL_RESET;
        end
        primask_r <= `PRI_LOWEST;
        insvc_r <= 7'h00;
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata <= 32'h00000000;
    end else begin
        o_pready <= i_psel & i_penable & ~o_pready;
        o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
        o_prdata <= 32'h00000000;
        if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
            o_prdata <= prdata_nxt;
        end
        if (wr & ctl_hit) begin
            ctl_r[ctl_idx] <= i_pwdata[6:0];
        end
        if (wr & (i_paddr == `OFS_PRIMASK)) begin
            primask_r <= i_pwdata[2:0];
        end
        insvc_r <= insvc_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// Acknowledge sequencer

always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        state_r <= ST_IDLE;
        cnt_r <= 6'h00;
        win_r <= 4'h0;
        cur_r <= 4'h0;
        o_irq_req <= 1'b0;
        o_vec_addr <= 10'h000;
        o_vec_valid <= 1'b0;
        o_ack_strobe_zero_n <= 1'b1;
        o_ack_strobe_one_n <= 1'b1;
        o_bus_lock <= 1'b0;
        o_bus_status_lines <= `BUS_STS_IDLE;
    end else begin
        o_vec_valid <= 1'b0;
        case (state_r)
            ST_IDLE: begin
                o_irq_req <= best_found & ~acc;
                win_r <= best_idx;
                cnt_r <= 6'h01;
                if (acc) begin
                    cur_r <= win_r;
                    if (casc) begin
                        state_r <= ST_ACK1;
                        o_ack_strobe_zero_n <= (win_r != `SRC_EXT0);
                        o_ack_strobe_one_n <= (win_r != `SRC_EXT1);
                        o_bus_lock <= 1'b1;
                        o_bus_status_lines <= `BUS_STS_ACK;
                    end else begin
                        // No strobes, lock or status here; vector stays inside
                        state_r <= ST_INT_WAIT;
                    end
                end
            end
            ST_INT_WAIT: begin
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == `RESP_INT_CYC - 6'h01) begin
                    state_r <= ST_DONE;
                    o_vec_addr <= {t_int, 2'h0};
                    o_vec_valid <= 1'b1;
                end
            end
            ST_ACK1: begin
                cnt_r <= 6'h00;
                // Waits forever without ready; external logic must answer
                if (i_ready) begin
                    state_r <= ST_GAP;
                    o_ack_strobe_zero_n <= 1'b1;
                    o_ack_strobe_one_n <= 1'b1;
                    o_bus_status_lines <= `BUS_STS_IDLE;
                end
            end
            ST_GAP: begin
                // Gap is fixed; idle states taken by other bus cycles are not modelled
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r == `IDLE_TS - 6'h01) begin
                    state_r <= ST_ACK2;
                    o_ack_strobe_zero_n <= (cur_r != `SRC_EXT0);
                    o_ack_strobe_one_n <= (cur_r != `SRC_EXT1);
                    o_bus_status_lines <= `BUS_STS_ACK;
                end
            end
            ST_ACK2: begin
                if (i_ready) begin
                    state_r <= ST_DONE;
                    o_vec_addr <= {i_ad_low, 2'h0};
                    o_vec_valid <= 1'b1;
                    o_ack_strobe_zero_n <= 1'b1;
                    o_ack_strobe_one_n <= 1'b1;
                    o_bus_lock <= 1'b0;
                    o_bus_status_lines <= `BUS_STS_IDLE;
                end
            end
            ST_DONE: begin
                // One spare cycle lets arbitration see the fresh in-service bit
                state_r <= ST_IDLE;
            end
            default: begin
                state_r <= ST_IDLE;
            end
        endcase
    end
end

endmodule

////////////////////////////////////////////////////////////////////////
// One external request pin

module irq_ext_pin_cell (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_pin,
    input wire i_level_mode,
    input wire i_clr,
    output reg o_req
);

reg armed_r;

// Disarmed at reset so a pin already high does not count as an edge
always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
        o_req <= 1'b0;
        armed_r <= 1'b0;
    end else begin
        if (!i_pin) begin
            o_req <= 1'b0;
            armed_r <= 1'b1;
        end else if (i_level_mode) begin
            // Level request follows the pin; in-service blocks re-entry
            o_req <= 1'b1;
        end else if (armed_r) begin
            o_req <= ~i_clr;
            armed_r <= 1'b0;
        end else if (i_clr) begin
            o_req <= 1'b0;
        end
    end
end

endmodule

/* File: sim/irq_ext_vec_asserts.sv */
`timescale 1ns/1ps
module irq_ext_vec_chk (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire o_irq_req,
    input wire i_irq_ack,
    input wire i_ready,
    input wire o_vec_valid,
    input wire o_ack_strobe_zero_n,
    input wire o_ack_strobe_one_n,
    input wire o_bus_lock,
    input wire [2:0] o_bus_status_lines
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    wire ack_lo = !o_ack_strobe_zero_n || !o_ack_strobe_one_n;
    ////////////////////////////////////////////////////////////////
    sequence s_accept;
        o_irq_req && i_irq_ack;
    endsequence
    // A third strobe inside the gap would look like a new acknowledge
    sequence s_gap;
        (!ack_lo) [*2] ##1 ack_lo;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_strobe_exclusive: assert property (o_ack_strobe_zero_n || o_ack_strobe_one_n)
        else $error("both strobes low");
    a_ack_status: assert property (o_bus_status_lines == (ack_lo ? 3'h0 : 3'h7))
        else $error("status lines wrong");
    a_lock_covers: assert property (ack_lo |-> o_bus_lock)
        else $error("strobe without lock");
    a_gap_two_idle: assert property ($rose(!ack_lo) && o_bus_lock |-> s_gap)
        else $error("gap not two idles");
    a_wait_ready: assert property (ack_lo && !i_ready |=> ack_lo)
        else $error("strobe ended without ready");
    a_internal_time: assert property (s_accept ##1 !ack_lo |-> ##[41:42] o_vec_valid)
        else $error("internal vector late");
    a_req_drops: assert property (s_accept |=> !o_irq_req)
        else $error("request kept after accept");
    a_lock_release: assert property ($fell(o_bus_lock) |-> o_vec_valid && !ack_lo)
        else $error("lock fell without vector");
endmodule
bind irq_ext_vec irq_ext_vec_chk u_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .o_irq_req(o_irq_req), .i_irq_ack(i_irq_ack), .i_ready(i_ready), .o_vec_valid(o_vec_valid),
    .o_ack_strobe_zero_n(o_ack_strobe_zero_n), .o_ack_strobe_one_n(o_ack_strobe_one_n),
    .o_bus_lock(o_bus_lock), .o_bus_status_lines(o_bus_status_lines));

/* File: sim/irq_far_side.sv */
`timescale 1ns/1ps
module irq_far_side (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_irq_req,
    input wire i_ack_zero_n,
    input wire i_ack_one_n,
    input wire [1:0] i_wait,
    input wire [7:0] i_slave_type,
    output reg o_irq_ack,
    output wire o_ready,
    output wire [7:0] o_ad_low
);
    reg [1:0] wait_cnt_r;
    wire in_ack = !i_ack_zero_n || !i_ack_one_n;
    // Slave answers after i_wait wait states
    assign o_ready = in_ack && (wait_cnt_r == i_wait);
    // Undriven bus shows the inverted type so a stale copy cannot pass
    assign o_ad_low = o_ready ? i_slave_type : ~i_slave_type;
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_ack <= 1'b0;
            wait_cnt_r <= 2'h0;
        end else begin
            o_irq_ack <= i_irq_req && !o_irq_ack;
            wait_cnt_r <= (in_ack && !o_ready) ? wait_cnt_r + 2'h1 : 2'h0;
        end
    end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam [39:0] TYS = 40'h0812131415;
    reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
    reg [7:0] paddr = 8'h00, a8, st = 8'h00;
    reg [31:0] pwdata = 32'h0, q;
    reg [2:0] tmr = 3'h0;
    reg rx = 0, tx = 0, e0 = 0, e1 = 0, e2 = 0, e3 = 0, e4 = 0;
    reg [1:0] wt = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, req, ack, rdy, vv, z_n, o_n, lock;
    wire [7:0] ad;
    wire [9:0] va;
    wire [2:0] sts;
    integer num_errors = 0, compares = 0, n_z = 0, n_o = 0, i;
    always #10 clk = ~clk;
    always @(negedge z_n) n_z = n_z + 1;
    always @(negedge o_n) n_o = n_o + 1;
    irq_ext_vec uut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_tmr_evt(tmr), .i_ser_rx_evt(rx), .i_ser_tx_evt(tx), .i_ext_irq_zero(e0), .i_ext_irq_one(e1),
        .i_ext_irq_two(e2), .i_ext_irq_three(e3), .i_ext_irq_four(e4), .o_irq_req(req), .i_irq_ack(ack),
        .i_ready(rdy), .i_ad_low(ad), .o_vec_addr(va), .o_vec_valid(vv), .o_ack_strobe_zero_n(z_n),
        .o_ack_strobe_one_n(o_n), .o_bus_lock(lock), .o_bus_status_lines(sts));
    irq_far_side far (.i_ref_clk(clk), .i_arst_n(rst_n), .i_irq_req(req), .i_ack_zero_n(z_n),
        .i_ack_one_n(o_n), .i_wait(wt), .i_slave_type(st), .o_irq_ack(ack), .o_ready(rdy), .o_ad_low(ad));
    ////////////////////////////////////////////////////////////////
    task end_of_test;
        begin
            if (num_errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task bail;
        begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r, output e);
        integer k;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pen <= 1'b0;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                k = k + 1;
            end while (pready !== 1'b1 && k < 50);
            if (k >= 50) bail;
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d, q, err);
    endtask
    task rd(input string nm, input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0, q, err);
            chk(nm, e, q);
        end
    endtask
    // Bounded wait; the pulse is seen as the value held up to the edge
    task vec(input string nm, input [9:0] e);
        integer k;
        begin
            k = 0;
            while (vv !== 1'b1 && k < 300) begin
                @(posedge clk);
                k = k + 1;
            end
            if (k >= 300) bail;
            chk(nm, {22'h0, e}, {22'h0, va});
        end
    endtask
    task pulse(input [4:0] m);
        begin
            @(posedge clk);
            {tx, rx, tmr} <= m;
            @(posedge clk);
            {tx, rx, tmr} <= 5'h00;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (a8 = 8'h00; a8 < 8'h1c; a8 = a8 + 8'h04) rd("ctl reset", a8, 32'h0f);
        rd("primask reset", 8'h1c, 32'h7);
        apb(1'b0, 8'h30, 32'h0, q, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        wr(8'h00, 32'h07);
        wr(8'h04, 32'h07);
        for (i = 0; i < 5; i = i + 1) begin
            if (i == 0) pulse(5'h07);
            if (i == 3) pulse(5'h18);
            vec("internal vector", {TYS[39-8*i -: 8], 2'b00});
            rd("in service", 8'h20, (i < 3) ? 32'h1 : 32'h2);
            repeat (5) @(posedge clk);
            chk("line blocked", 32'h0, {31'h0, req});
            wr(8'h20, 32'h0);
        end
        e2 <= 1'b1;
        repeat (3) @(posedge clk);
        rd("edge request", 8'h24, 32'h100);
        e2 <= 1'b0;
        repeat (3) @(posedge clk);
        rd("request follows pin", 8'h24, 32'h0);
        e2 <= 1'b1;
        repeat (3) @(posedge clk);
        rd("rearmed", 8'h24, 32'h100);
        e2 <= 1'b0;
        wr(8'h08, 32'h07);
        e4 <= 1'b1;
        vec("ext4 vector", 10'h044);
        e4 <= 1'b0;
        wr(8'h20, 32'h0);
        wr(8'h10, 32'h17);
        e1 <= 1'b1;
        vec("ext1 level", 10'h034);
        e1 <= 1'b0;
        wr(8'h20, 32'h0);
        // Slow slave first, then a prompt one
        for (i = 0; i < 2; i = i + 1) begin
            wt <= {~i[0], 1'b0};
            st <= 8'h45 + i[7:0];
            wr(8'h0c + {i[5:0], 2'b00}, 32'h37);
            {e1, e0} <= i[0] ? 2'b10 : 2'b01;
            vec("cascade type", {8'h45 + i[7:0], 2'b00});
            {e1, e0} <= 2'b00;
            wr(8'h20, 32'h0);
        end
        chk("strobe zero pulses", 32'h2, n_z);
        chk("strobe one pulses", 32'h2, n_o);
        // Special nesting: a held level on ext0 is taken again while in service
        wr(8'h0c, 32'h57);
        e0 <= 1'b1;
        vec("nested first", 10'h030);
        @(posedge clk);
        vec("nested again", 10'h030);
        e0 <= 1'b0;
        wr(8'h20, 32'h0);
        end_of_test;
    end
endmodule
